// >>> verilog/sp1u_serial_port.sv
// Full-duplex serial port with baud generator and AXI4-Lite registers.

// Contract
// [R1] Bit rate is clock over sixteen times reload-plus-one.
// [R2] Separate transmit and receive down-counters reload at zero.
// [R3] Data write starts sending; writes while busy dropped.
// [R4] Sending begins at the next transmit bit tick.
// [R5] 8-bit frame: low start, data LSB first, high stop.
// [R6] Stop bit start pulses end, setting transmit done flag.
// [R7] Receiver works only while receive enable is set.
// [R8] Falling edge restarts the 4-bit slice counter.
// [R9] Sample slices 6, 7, 8; take the majority.
// [R10] Shift decided bit into shifter at slice 9.
// [R11] Nonzero start bit aborts frame, await next edge.
// [R12] 8-bit: accept on stop if free and filter passes.
// [R13] 9-bit: ninth bit sent after data, before stop.
// [R14] 9-bit: accept on ninth bit if free and filter passes.
// [R15] Modes 0/1 are 8-bit, modes 2/3 are 9-bit.
// [R16] Interrupt is done flags ORed, gated by enable bit.
// [R17] Software clears done flags; hardware never does.
// [R18] Command mode suppresses interrupt unless direct access set.
// [R19] Reading data buffer returns received holding register.
// [R20] Master marks address bytes with ninth bit high.
// [R21] Chosen reload should keep rate error within 5%.
// [R22] Receive line passes a two-stage synchroniser first.
module sp1u_serial_port
  import sp1u_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmd_detected,
  input wire logic rx_line,
  output logic tx_line,
  output logic serial_irq
);

  // Bus slave state. The ready flags double as "holding register empty".
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [15:0] aw_idx_q;
  logic aw_hi_ok_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;

  // Software-visible registers.
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] baud_lo_q, baud_hi_q, ie_q, sysctl_q;
  logic [7:0] tx_hold_reg_q, rx_hold_reg_q;
  logic irq_q;

  // Transmitter.
  sp1u_tx_state_t tx_state_q;
  logic [15:0] tx_baud_q;
  logic [3:0] tx_slice_q;
  logic [9:0] tx_shift_q;
  logic [3:0] tx_left_q;
  logic tx_line_q;

  // Receiver.
  sp1u_rx_state_t rx_state_q;
  logic rx_sync1_q, rx_sync2_q, rx_prev_q;
  logic [15:0] rx_baud_q;
  logic [3:0] rx_slice_q;
  logic [3:0] rx_bit_q;
  logic [2:0] rx_samp_q;
  logic [7:0] rx_shifter_q;

  // Bus decode.
  wire logic do_write = ~awready_q & ~wready_q & ~bvalid_q;
  wire logic wr_lane = do_write & wstrb0_q & aw_hi_ok_q;
  wire logic wr_ctrl = wr_lane & (aw_idx_q == SP1U_IDX_CTRL);
  wire logic wr_data = wr_lane & (aw_idx_q == SP1U_IDX_DATA);
  wire logic wr_baudl = wr_lane & (aw_idx_q == SP1U_IDX_BAUDL);
  wire logic wr_baudh = wr_lane & (aw_idx_q == SP1U_IDX_BAUDH);
  wire logic wr_ie = wr_lane & (aw_idx_q == SP1U_IDX_IE);
  wire logic wr_sysctl = wr_lane & (aw_idx_q == SP1U_IDX_SYSCTL);
  wire logic aw_mapped = aw_hi_ok_q & ((aw_idx_q == SP1U_IDX_CTRL) |
      (aw_idx_q == SP1U_IDX_DATA) | (aw_idx_q == SP1U_IDX_BAUDL) |
      (aw_idx_q == SP1U_IDX_BAUDH) | (aw_idx_q == SP1U_IDX_IE) |
      (aw_idx_q == SP1U_IDX_SYSCTL));

  wire logic rd_take = s_axi_arvalid & arready_q;
  wire logic rd_hi_ok = (s_axi_araddr[31:18] == 14'h0000);
  wire logic [15:0] rd_idx = s_axi_araddr[17:2];
  wire logic rd_ctrl = rd_hi_ok & (rd_idx == SP1U_IDX_CTRL);
  wire logic rd_data = rd_hi_ok & (rd_idx == SP1U_IDX_DATA);
  wire logic rd_baudl = rd_hi_ok & (rd_idx == SP1U_IDX_BAUDL);
  wire logic rd_baudh = rd_hi_ok & (rd_idx == SP1U_IDX_BAUDH);
  wire logic rd_ie = rd_hi_ok & (rd_idx == SP1U_IDX_IE);
  wire logic rd_sysctl = rd_hi_ok & (rd_idx == SP1U_IDX_SYSCTL);
  wire logic rd_mapped = rd_ctrl | rd_data | rd_baudl | rd_baudh |
      rd_ie | rd_sysctl;
  wire logic [7:0] rd_byte =
      rd_ctrl ? ctrl_q :
      rd_data ? rx_hold_reg_q : // [R19]
      rd_baudl ? baud_lo_q :
      rd_baudh ? baud_hi_q :
      rd_ie ? ie_q :
      rd_sysctl ? sysctl_q : 8'h00;

  // Mode and control fields.
  wire logic [15:0] baud_reload = {baud_hi_q, baud_lo_q};
  wire logic nine_bit = ctrl_q[SP1U_CTRL_MODE_HI]; // [R15]
  wire logic rx_enable = ctrl_q[SP1U_CTRL_REN];
  wire logic multiproc_filter = ctrl_q[SP1U_CTRL_MP_FILT];

  // Baud timing: one slice each time a counter reaches zero.
  wire logic tx_slice_tick = (tx_baud_q == 16'h0000); // [R1]
  wire logic tx_bit_tick = tx_slice_tick & (tx_slice_q == SP1U_SLICE_LAST);
  wire logic rx_slice_tick = (rx_baud_q == 16'h0000); // [R1]

  // Transmit control.
  wire logic tx_free = (tx_state_q == SP1U_TX_IDLE);
  wire logic tx_load = wr_data & tx_free; // [R3]
  wire logic tx_start = (tx_state_q == SP1U_TX_WAIT) & tx_bit_tick; // [R4]
  wire logic tx_step = (tx_state_q == SP1U_TX_SEND) & tx_bit_tick;
  wire logic tx_last = (tx_left_q == 4'h1);
  // The stop bit goes out when two bits are left before the shift.
  wire logic tx_end_pulse = tx_step & (tx_left_q == 4'h2); // [R6]

  // Receive control.
  wire logic rx_fall = rx_prev_q & ~rx_sync2_q;
  wire logic rx_begin = (rx_state_q == SP1U_RX_IDLE) & rx_enable & rx_fall;
  wire logic rx_run = (rx_state_q == SP1U_RX_RUN);
  wire logic rx_majority = (rx_samp_q[0] & rx_samp_q[1]) |
      (rx_samp_q[0] & rx_samp_q[2]) | (rx_samp_q[1] & rx_samp_q[2]); // [R9]
  wire logic rx_decide = rx_run & rx_slice_tick &
      (rx_slice_q == SP1U_SHIFT_SLICE);
  wire logic rx_bad_start = rx_decide & (rx_bit_q == 4'h0) &
      rx_majority; // [R11]
  wire logic rx_final = rx_decide & (rx_bit_q == SP1U_RX_LAST_BIT);
  wire logic rx_accept = rx_final & ~ctrl_q[SP1U_CTRL_RX_DONE] &
      (~multiproc_filter | rx_majority); // [R12] [R14]

  // Interrupt request: flags ORed, gated, and hidden in command mode unless direct access is set.
  wire logic irq_d = (ctrl_q[SP1U_CTRL_RX_DONE] |
      ctrl_q[SP1U_CTRL_TX_DONE]) & ie_q[SP1U_IE_SERIAL] &
      (sysctl_q[SP1U_SYSCTL_DAM] | ~cmd_detected); // [R16] [R18]

  // Flags are set by hardware and cleared only by software writes; a set
  // in the same cycle as a software clear wins.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = wdata_q; // [R17]
    end
    if (tx_end_pulse) begin
      ctrl_d[SP1U_CTRL_TX_DONE] = 1'b1; // [R6]
    end
    if (rx_accept) begin
      ctrl_d[SP1U_CTRL_RX_DONE] = 1'b1;
      ctrl_d[SP1U_CTRL_RX_NINTH] = rx_majority;
    end
  end

  // Write channel: take address and data in either order, answer once both.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= SP1U_RESP_OKAY;
      aw_idx_q <= 16'h0000;
      aw_hi_ok_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid & awready_q) begin
        awready_q <= 1'b0;
        aw_idx_q <= s_axi_awaddr[17:2];
        aw_hi_ok_q <= (s_axi_awaddr[31:18] == 14'h0000);
      end
      if (s_axi_wvalid & wready_q) begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= aw_mapped ? SP1U_RESP_OKAY : SP1U_RESP_SLVERR;
      end
      if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channel: one read at a time, answered the cycle after address.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= SP1U_RESP_OKAY;
    end else if (rd_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_mapped ? SP1U_RESP_OKAY : SP1U_RESP_SLVERR;
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Software registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= SP1U_CTRL_RST;
      baud_lo_q <= SP1U_BAUD_RST[7:0];
      baud_hi_q <= SP1U_BAUD_RST[15:8];
      ie_q <= SP1U_IE_RST;
      sysctl_q <= SP1U_SYSCTL_RST;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_q <= irq_d;
      if (wr_baudl) begin
        baud_lo_q <= wdata_q;
      end
      if (wr_baudh) begin
        baud_hi_q <= wdata_q;
      end
      if (wr_ie) begin
        ie_q <= wdata_q;
      end
      if (wr_sysctl) begin
        sysctl_q <= wdata_q;
      end
    end
  end

  // Transmit baud counter and slice counter.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_baud_q <= SP1U_BAUD_RST;
      tx_slice_q <= 4'h0;
    end else begin
      tx_baud_q <= tx_slice_tick ? baud_reload : tx_baud_q - 16'h0001; // [R2]
      if (tx_slice_tick) begin
        tx_slice_q <= tx_slice_q + 4'h1;
      end
    end
  end

  // Transmitter: the shifter holds the bits still to send after the
  // current one, filling with ones so the line idles high.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state_q <= SP1U_TX_IDLE;
      tx_hold_reg_q <= 8'h00;
      tx_shift_q <= 10'h3FF;
      tx_left_q <= 4'h0;
      tx_line_q <= 1'b1;
    end else begin
      case (tx_state_q)
        SP1U_TX_IDLE: begin
          if (tx_load) begin
            tx_hold_reg_q <= wdata_q; // [R3]
            tx_state_q <= SP1U_TX_WAIT;
          end
        end
        SP1U_TX_WAIT: begin
          if (tx_start) begin
            tx_line_q <= 1'b0; // [R5]
            tx_state_q <= SP1U_TX_SEND;
            if (nine_bit) begin
              tx_shift_q <= {1'b1, ctrl_q[SP1U_CTRL_TX_NINTH],
                  tx_hold_reg_q}; // [R13]
              tx_left_q <= SP1U_TX_BITS_9;
            end else begin
              tx_shift_q <= {2'b11, tx_hold_reg_q}; // [R5]
              tx_left_q <= SP1U_TX_BITS_8;
            end
          end
        end
        SP1U_TX_SEND: begin
          if (tx_step) begin
            if (tx_last) begin
              tx_state_q <= SP1U_TX_IDLE;
              tx_left_q <= 4'h0;
            end else begin
              tx_line_q <= tx_shift_q[0]; // [R5]
              tx_shift_q <= {1'b1, tx_shift_q[9:1]};
              tx_left_q <= tx_left_q - 4'h1;
            end
          end
        end
        default: begin
          tx_state_q <= SP1U_TX_IDLE;
        end
      endcase
    end
  end

  // Receive line synchroniser and edge history.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sync1_q <= 1'b1;
      rx_sync2_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_sync1_q <= rx_line; // [R22]
      rx_sync2_q <= rx_sync1_q; // [R22]
      rx_prev_q <= rx_sync2_q;
    end
  end

  // Receive baud counter, realigned by the start edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_baud_q <= SP1U_BAUD_RST;
    end else if (rx_begin | rx_slice_tick) begin
      rx_baud_q <= baud_reload; // [R2] [R8]
    end else begin
      rx_baud_q <= rx_baud_q - 16'h0001; // [R2]
    end
  end

  // Receiver: bit 0 is the start bit, 1 to 8 data, 9 stop or ninth bit.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state_q <= SP1U_RX_IDLE;
      rx_slice_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_samp_q <= 3'b111;
      rx_shifter_q <= 8'h00;
      rx_hold_reg_q <= 8'h00;
    end else begin
      case (rx_state_q)
        SP1U_RX_IDLE: begin
          if (rx_begin) begin
            rx_slice_q <= 4'h0; // [R8]
            rx_bit_q <= 4'h0;
            rx_state_q <= SP1U_RX_RUN; // [R7]
          end
        end
        SP1U_RX_RUN: begin
          if (~rx_enable | rx_bad_start | rx_final) begin
            rx_state_q <= SP1U_RX_IDLE; // [R7] [R11]
          end
          if (rx_slice_tick) begin
            rx_slice_q <= rx_slice_q + 4'h1;
            if (rx_slice_q == SP1U_SLICE_LAST) begin
              rx_bit_q <= rx_bit_q + 4'h1;
            end
            if (rx_slice_q == SP1U_SAMP_A) begin
              rx_samp_q[0] <= rx_sync2_q; // [R9]
            end
            if (rx_slice_q == SP1U_SAMP_B) begin
              rx_samp_q[1] <= rx_sync2_q; // [R9]
            end
            if (rx_slice_q == SP1U_SAMP_C) begin
              rx_samp_q[2] <= rx_sync2_q; // [R9]
            end
          end
          if (rx_decide & (rx_bit_q != 4'h0) & ~rx_final) begin
            rx_shifter_q <= {rx_majority, rx_shifter_q[7:1]}; // [R10]
          end
          if (rx_accept) begin
            rx_hold_reg_q <= rx_shifter_q; // [R12] [R14]
          end
        end
        default: begin
          rx_state_q <= SP1U_RX_IDLE;
        end
      endcase
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign tx_line = tx_line_q;
  assign serial_irq = irq_q;

endmodule : sp1u_serial_port

// >>> verilog/sp1u_pkg.sv
// Package with register map, field positions, reset values and states.
package sp1u_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] SP1U_IDX_CTRL = 16'h0098;
  localparam logic [15:0] SP1U_IDX_DATA = 16'h0099;
  localparam logic [15:0] SP1U_IDX_BAUDL = 16'h009A;
  localparam logic [15:0] SP1U_IDX_BAUDH = 16'h009B;
  localparam logic [15:0] SP1U_IDX_IE = 16'h00A8;
  localparam logic [15:0] SP1U_IDX_SYSCTL = 16'h9001;

  // Field positions in serial_ctrl.
  localparam int SP1U_CTRL_RX_DONE = 0;
  localparam int SP1U_CTRL_TX_DONE = 1;
  localparam int SP1U_CTRL_RX_NINTH = 2;
  localparam int SP1U_CTRL_TX_NINTH = 3;
  localparam int SP1U_CTRL_REN = 4;
  localparam int SP1U_CTRL_MP_FILT = 5;
  localparam int SP1U_CTRL_MODE_LO = 6;
  localparam int SP1U_CTRL_MODE_HI = 7;
  // Field positions in the enable and system-control registers.
  localparam int SP1U_IE_SERIAL = 4;
  localparam int SP1U_SYSCTL_DAM = 0;

  // Reset values.
  localparam logic [7:0] SP1U_CTRL_RST = 8'h00;
  localparam logic [15:0] SP1U_BAUD_RST = 16'h0000;
  localparam logic [7:0] SP1U_IE_RST = 8'h00;
  localparam logic [7:0] SP1U_SYSCTL_RST = 8'h00;

  // Slice timing inside one serial bit.
  localparam logic [3:0] SP1U_SLICE_LAST = 4'hF;
  localparam logic [3:0] SP1U_SAMP_A = 4'h6;
  localparam logic [3:0] SP1U_SAMP_B = 4'h7;
  localparam logic [3:0] SP1U_SAMP_C = 4'h8;
  localparam logic [3:0] SP1U_SHIFT_SLICE = 4'h9;

  // Frame lengths in bits on the line, start and stop included.
  localparam logic [3:0] SP1U_TX_BITS_8 = 4'hA;
  localparam logic [3:0] SP1U_TX_BITS_9 = 4'hB;
  // Receive bit index of the stop bit (8-bit) or ninth bit (9-bit).
  localparam logic [3:0] SP1U_RX_LAST_BIT = 4'h9;

  // AXI responses.
  localparam logic [1:0] SP1U_RESP_OKAY = 2'h0;
  localparam logic [1:0] SP1U_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SP1U_TX_IDLE = 2'b00,
    SP1U_TX_WAIT = 2'b01,
    SP1U_TX_SEND = 2'b11
  } sp1u_tx_state_t;

  typedef enum logic {
    SP1U_RX_IDLE = 1'b0,
    SP1U_RX_RUN = 1'b1
  } sp1u_rx_state_t;

endpackage : sp1u_pkg

// >>> sim/sp1u_serial_port_chk.sv
// Checks on the serial port's bus, transmit line and interrupt output.
module sp1u_serial_port_chk
  import sp1u_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmd_detected,
  input wire logic rx_line,
  input wire logic tx_line,
  input wire logic serial_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] idx_q, rl_q;
  logic [7:0] wd_q;
  logic bv_q, es_q, dam_q, tx_q, ws_q;
  logic [31:0] run_q;
  // Only a write with its low byte lane enabled changes a register.
  wire logic lands = s_axi_bvalid && !bv_q && ws_q &&
    s_axi_bresp == SP1U_RESP_OKAY;
  wire logic [31:0] bit_len = {12'h0, rl_q + 16'h1, 4'h0};

  // Shadow bits follow each write when its response appears.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_q <= '0;
      wd_q <= '0;
      ws_q <= 1'b1;
      rl_q <= SP1U_BAUD_RST;
      bv_q <= 1'b0;
      es_q <= 1'b0;
      dam_q <= 1'b0;
      tx_q <= 1'b1;
      run_q <= 32'h1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) idx_q <= s_axi_awaddr[17:2];
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
      if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb[0];
      bv_q <= s_axi_bvalid;
      if (lands && idx_q == SP1U_IDX_BAUDL) rl_q[7:0] <= wd_q;
      if (lands && idx_q == SP1U_IDX_BAUDH) rl_q[15:8] <= wd_q;
      if (lands && idx_q == SP1U_IDX_IE) es_q <= wd_q[SP1U_IE_SERIAL];
      if (lands && idx_q == SP1U_IDX_SYSCTL) dam_q <= wd_q[SP1U_SYSCTL_DAM];
      tx_q <= tx_line;
      run_q <= (tx_line != tx_q) ? 32'h1 : run_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_irq_gated: assert property (
    serial_irq |-> es_q && (dam_q || !$past(cmd_detected)))
    else $error("serial interrupt raised while gated off");
  a_tx_bit_len: assert property (
    $rose(tx_line) |-> run_q % bit_len == 32'h0)
    else $error("low run on transmit line not whole bit times");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_b_follows: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_r_follows: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_busy_no_take: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rdata_byte: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");

  c_irq: cover property ($rose(serial_irq));
  c_tx: cover property ($fell(tx_line));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == SP1U_RESP_SLVERR);
endmodule : sp1u_serial_port_chk

bind sp1u_serial_port sp1u_serial_port_chk u_sp1u_serial_port_chk (.*);

// >>> sim/sp1u_remote_uart.sv
// Remote serial party: sends frames to the receiver, decodes sent frames.
module sp1u_remote_uart #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial line_out = 1'b1;

  task automatic send(input logic [10:0] f, input int n);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line_out <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask : send

  // A low pulse far shorter than the sample point, a false start.
  task automatic glitch();
    @(posedge clk);
    line_out <= 1'b0;
    repeat (4) @(posedge clk);
    line_out <= 1'b1;
  endtask : glitch

  // Samples n bits mid-bit after a falling edge; bits not sent read high.
  task automatic get(input int n, output logic [10:0] f);
    f = 11'h7FF;
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = line_in;
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask : get
endmodule : sp1u_remote_uart

// >>> sim/sp1u_serial_port_test.sv
// Self-checking bench for the serial port: registers, frames, interrupt.
module sp1u_serial_port_test
  import sp1u_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 32;
  localparam logic [1:0] OK = SP1U_RESP_OKAY;
  logic clk, rst, cmd_detected, rx_line, tx_line, serial_irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  typedef struct packed {
    logic [15:0] idx;
    logic [7:0] wd, ed;
    logic [1:0] rsp;
  } sp1u_reg_row_t;
  typedef struct packed {
    logic [7:0] ctl, d;
    logic b9, nine;
    logic [7:0] ed, ec;
  } sp1u_rx_row_t;
  sp1u_reg_row_t regs [9] = '{'{SP1U_IDX_BAUDL, 8'h5A, 8'h5A, OK},
    '{SP1U_IDX_BAUDH, 8'h01, 8'h01, OK}, '{SP1U_IDX_BAUDH, 8'h00, 8'h00, OK},
    '{SP1U_IDX_BAUDL, 8'h01, 8'h01, OK}, '{SP1U_IDX_CTRL, 8'hF8, 8'hF8, OK},
    '{SP1U_IDX_CTRL, 8'h00, 8'h00, OK}, '{SP1U_IDX_IE, 8'h10, 8'h10, OK},
    '{SP1U_IDX_SYSCTL, 8'h01, 8'h01, OK},
    '{16'h0050, 8'hFF, 8'h00, SP1U_RESP_SLVERR}};
  sp1u_rx_row_t rxr [9] = '{'{8'h10, 8'hF6, 1'b1, 1'b0, 8'hF6, 8'h15},
    '{8'hFF, 8'h11, 1'b1, 1'b0, 8'hF6, 8'h15},
    '{8'h30, 8'h22, 1'b0, 1'b0, 8'hF6, 8'h30},
    '{8'h30, 8'h33, 1'b1, 1'b0, 8'h33, 8'h35},
    '{8'h50, 8'h88, 1'b1, 1'b0, 8'h88, 8'h55},
    '{8'hB0, 8'h44, 1'b0, 1'b1, 8'h88, 8'hB0},
    '{8'hB0, 8'h55, 1'b1, 1'b1, 8'h55, 8'hB5},
    '{8'hD0, 8'h66, 1'b0, 1'b1, 8'h66, 8'hD1},
    '{8'h00, 8'h77, 1'b1, 1'b0, 8'h66, 8'h00}};

  sp1u_serial_port u_sp1u_serial_port (.*);
  sp1u_remote_uart #(.BIT_CLKS(BIT)) u_sp1u_remote_uart (.clk(clk),
    .line_in(tx_line), .line_out(rx_line));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= {14'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] idx);
    @(posedge clk);
    s_axi_araddr <= {14'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
    rd(idx);
    chk(rdv, {24'h0, e});
  endtask : rchk

  function automatic logic [10:0] fr(input logic [7:0] d, input logic b9);
    return {1'b1, b9, d, 1'b0};
  endfunction : fr

  initial begin
    logic [10:0] txf;
    int nb;
    int lowcnt;
    rst = 1'b1;
    cmd_detected = 1'b0;
    s_axi_awaddr = '0;
    s_axi_wdata = '0;
    s_axi_araddr = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[i]) begin
      wr(regs[i].idx, regs[i].wd);
      chk({30'h0, resp}, {30'h0, regs[i].rsp});
      rchk(regs[i].idx, regs[i].ed);
      chk({30'h0, resp}, {30'h0, regs[i].rsp});
    end
    // A write with the low byte lane off is answered but changes nothing.
    s_axi_wstrb <= 4'hE;
    wr(SP1U_IDX_IE, 8'h1F);
    chk({30'h0, resp}, {30'h0, OK});
    rchk(SP1U_IDX_IE, 8'h10);
    s_axi_wstrb <= 4'hF;
    foreach (rxr[i]) begin
      nb = rxr[i].nine ? 11 : 10;
      if (rxr[i].ctl !== 8'hFF) wr(SP1U_IDX_CTRL, rxr[i].ctl);
      u_sp1u_remote_uart.send(fr(rxr[i].d, rxr[i].b9), nb);
      rchk(SP1U_IDX_DATA, rxr[i].ed);
      rchk(SP1U_IDX_CTRL, rxr[i].ec);
      chk({31'h0, serial_irq}, {31'h0, rxr[i].ec[0]});
    end
    wr(SP1U_IDX_CTRL, 8'h10);
    u_sp1u_remote_uart.glitch();
    repeat (11 * BIT) @(posedge clk);
    u_sp1u_remote_uart.send(fr(8'h5C, 1'b1), 10);
    rchk(SP1U_IDX_DATA, 8'h5C);
    rchk(SP1U_IDX_CTRL, 8'h15);
    for (int m = 0; m < 4; m++) begin
      wr(SP1U_IDX_CTRL, {m[1:0], 6'h08});
      fork
        u_sp1u_remote_uart.get(m > 1 ? 11 : 10, txf);
        begin
          wr(SP1U_IDX_DATA, 8'hA5 ^ m[7:0]);
          wr(SP1U_IDX_DATA, 8'h3C);
        end
      join
      chk({21'h0, txf}, {21'h0, fr(8'hA5 ^ m[7:0], 1'b1)});
      rchk(SP1U_IDX_CTRL, {m[1:0], 6'h0A});
      chk({31'h0, serial_irq}, 32'h1);
    end
    lowcnt = 0;
    repeat (2 * BIT) begin
      @(posedge clk);
      if (tx_line !== 1'b1) lowcnt++;
    end
    chk(lowcnt, 0);
    cmd_detected <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, serial_irq}, 32'h1);
    wr(SP1U_IDX_SYSCTL, 8'h00);
    repeat (3) @(posedge clk);
    chk({31'h0, serial_irq}, 32'h0);
    cmd_detected <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, serial_irq}, 32'h1);
    wr(SP1U_IDX_IE, 8'h00);
    repeat (2) @(posedge clk);
    chk({31'h0, serial_irq}, 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk({31'h0, tx_line}, 32'h1);
    rchk(SP1U_IDX_CTRL, SP1U_CTRL_RST);
    rchk(SP1U_IDX_BAUDL, SP1U_BAUD_RST[7:0]);
    rchk(SP1U_IDX_IE, SP1U_IE_RST);
    rchk(SP1U_IDX_SYSCTL, SP1U_SYSCTL_RST);
    conclude();
  end
endmodule : sp1u_serial_port_test
